/* File: design/tws_core.sv */
`timescale 1ns/1ps
`include "tws_regs.svh"
module tws_core #(
   parameter int LOW_CYCLES = `TWS_LOW_CYC,
   parameter int FIFO_DEPTH = `TWS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       reset_i,
   // Data buffer access
   input  wire logic       buf_wr_i,
   input  wire logic [7:0] buf_wdata_i,
   input  wire logic       buf_rd_i,
   output logic      [7:0] buf_rdata_o,
   output logic            buf_ready_o,
   // Control register b write
   input  wire logic       ctrl_b_wr_i,
   input  wire logic       master_select_i,
   input  wire logic       transmit_select_i,
   input  wire logic       bus_busy_wr_i,
   input  wire logic       service_pending_wr_i,
   input  wire logic [1:0] bus_mode_select_i,
   // Control register a and address register
   input  wire logic       reply_bit_mode_i,
   input  wire logic [2:0] clock_rate_select_i,
   input  wire logic       word_length_wr_i,
   input  wire logic [2:0] word_length_i,
   input  wire logic [6:0] own_address_i,
   input  wire logic       free_format_select_i,
   // Status
   output logic            serial_bus_irq_o,
   output logic            service_pending_n_o,
   output logic            master_select_o,
   output logic            transmit_select_o,
   output logic            bus_busy_flag_o,
   output logic            arbitration_lost_o,
   output logic            address_hit_flag_o,
   output logic            zero_address_flag_o,
   output logic            last_bit_seen_o,
   output logic [2:0]      word_length_o,
   // Open-drain bus pins
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe_o,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o
);
   tws_pkg::tws_state_t state, next_state;
   logic [15:0]       cnt, next_cnt;
   logic [3:0]        bitcnt, next_bitcnt;
   tws_pkg::tws_byte_t shreg, next_shreg, rxbuf, next_rxbuf;
   logic [2:0]        wl, next_wl;
   logic [1:0]        mode, next_mode;
   logic pin, next_pin, master_select, next_mst, transmit_select, next_trx, bb, next_bb;
   logic al, next_al, address_hit_flag, next_aas, ad0, next_ad0, last_bit_seen, next_lrb;
   logic irq, next_irq, addressed, next_addressed, lost, next_lost;
   logic addr_phase, next_addr_phase, dir, next_dir;
   logic load_pend, next_load_pend, stop_pend, next_stop_pend;
   logic start_pend, next_start_pend;
   logic scl_oe, next_scl_oe, sda_oe, next_sda_oe, scl_q, sda_q;

   logic        enable, scl_rise, scl_fall, start_det, stop_det;
   logic        buf_touch, word_end, data_bit, ack_bit, match, low_done;
   logic        pop;
   logic [3:0]  nbits, total;
   logic [15:0] low_lim;

   tws_stream_if #(.WIDTH(`TWS_DATA_W)) tx_in ();
   tws_stream_if #(.WIDTH(`TWS_DATA_W)) tx_out ();

   // Written bytes queue up until the shifter is allowed to take one
   assign tx_in.valid  = buf_wr_i;
   assign tx_in.data   = buf_wdata_i;
   assign tx_out.ready = pop;

   tws_fifo #(
      .WIDTH (`TWS_DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .in_s      (tx_in),
      .out_s     (tx_out)
   );

   // Bus events and word framing
   assign enable    = (mode == `TWS_MODE_TWO_WIRE);
   assign scl_rise  = scl_i & ~scl_q;
   assign scl_fall  = ~scl_i & scl_q;
   assign start_det = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_det  = scl_i & scl_q & ~sda_q & sda_i;
   assign buf_touch = buf_wr_i | buf_rd_i;
   assign nbits     = (wl == 3'h0) ? `TWS_WL_FULL : {1'b0, wl};
   assign total     = nbits + {3'h0, reply_bit_mode_i};
   assign data_bit  = (bitcnt < nbits);
   assign ack_bit   = (bitcnt == nbits) & reply_bit_mode_i;
   assign word_end  = scl_fall & (bitcnt == total) & bb;
   assign match     = ~free_format_select_i
                      & ((shreg[7:1] == own_address_i) | (shreg == 8'h00));
   // Divider: one low period, scaled by the rate select
   assign low_lim   = 16'(LOW_CYCLES) << clock_rate_select_i;
   assign low_done  = (cnt >= low_lim - 16'h0001);
   assign pop       = load_pend & pin & transmit_select & tx_out.valid & (~scl_i | start_pend)
                      & (master_select | addressed);

   // Next values of the whole engine
   always_comb begin
      next_state      = state;
      next_cnt        = cnt;
      next_bitcnt     = bitcnt;
      next_shreg      = shreg;
      next_rxbuf      = rxbuf;
      next_wl         = wl;
      next_mode       = mode;
      next_pin        = pin;
      next_mst        = master_select;
      next_trx        = transmit_select;
      next_bb         = bb;
      next_al         = al;
      next_aas        = address_hit_flag;
      next_ad0        = ad0;
      next_lrb        = last_bit_seen;
      next_irq        = 1'b0;
      next_addressed  = addressed;
      next_lost       = lost;
      next_addr_phase = addr_phase;
      next_dir        = dir;
      next_load_pend  = load_pend;
      next_stop_pend  = stop_pend;
      next_start_pend = start_pend;
      next_scl_oe     = scl_oe;
      next_sda_oe     = sda_oe;

      // Software side; clears come first so hardware sets win
      if (buf_touch) begin
         next_pin = 1'b1;
         next_aas = 1'b0;
      end
      if (buf_touch | ctrl_b_wr_i) begin
         next_al = 1'b0;
      end
      if (word_length_wr_i) begin
         next_wl = word_length_i;
      end
      if (ctrl_b_wr_i) begin
         next_mode = bus_mode_select_i;
         if (service_pending_wr_i) begin
            next_pin = 1'b1;  // Zero is ignored
         end
         if (master_select_i & transmit_select_i & service_pending_wr_i) begin
            if (bus_busy_wr_i & ~bb) begin
               next_mst        = 1'b1;
               next_trx        = 1'b1;
               next_start_pend = 1'b1;
               next_load_pend  = 1'b1;
            end else if (~bus_busy_wr_i & bb & master_select) begin
               next_stop_pend = 1'b1;
            end
         end else begin
            next_mst = master_select_i;
            next_trx = transmit_select_i;
         end
      end

      // Shifter takes a byte while SCL is low, or idle before a start
      if (pop) begin
         next_shreg     = tx_out.data;
         next_load_pend = 1'b0;
         if (addr_phase | start_pend) begin
            next_dir = tx_out.data[0];
         end
      end

      // Bit sampling and arbitration at the rising edge
      if (scl_rise & bb) begin
         next_lrb = sda_i;
         if (data_bit) begin
            next_shreg  = {shreg[6:0], sda_i};
            if (master_select & transmit_select & ~sda_oe & ~sda_i) begin
               next_al     = 1'b1;
               next_mst    = 1'b0;
               next_trx    = 1'b0;
               next_lost   = 1'b1;
               next_state  = tws_pkg::TWS_IDLE;
               next_scl_oe = 1'b0;
               next_sda_oe = 1'b0;
            end
         end
         next_bitcnt = bitcnt + 4'h1;
      end

      // End of a word, acknowledge slot included
      if (word_end) begin
         next_bitcnt     = 4'h0;
         next_rxbuf      = shreg;
         next_addr_phase = 1'b0;
         if (master_select) begin
            next_irq       = 1'b1;
            next_pin       = 1'b0;
            next_load_pend = 1'b1;
            // Ack taken at the ninth rise; SDA is already free at the fall
            if (addr_phase & ~last_bit_seen) begin
               next_trx = ~dir;
            end
         end else if (addr_phase) begin
            next_ad0 = (shreg == 8'h00);
            if (free_format_select_i) begin
               next_aas       = 1'b1;
               next_addressed = 1'b1;
               next_irq       = 1'b1;
               next_pin       = 1'b0;
            end else if (match) begin
               next_aas       = 1'b1;
               next_addressed = 1'b1;
               next_trx       = shreg[0] & (shreg != 8'h00);
               next_load_pend = 1'b1;
               next_irq       = 1'b1;
               next_pin       = 1'b0;
            end else if (lost) begin
               next_irq = 1'b1;  // Flag left alone
            end
            next_lost = 1'b0;
         end else if (addressed) begin
            next_irq       = 1'b1;
            next_pin       = 1'b0;
            next_load_pend = transmit_select;
         end else if (lost) begin
            next_irq  = 1'b1;
            next_lost = 1'b0;
         end
      end

      // SDA driving decided while SCL is low
      if (~scl_i & bb & (state != tws_pkg::TWS_STOP_LOW)) begin
         next_sda_oe = enable & (
            (transmit_select & data_bit & ~shreg[7] & (master_select | addressed))
            | (ack_bit & ~transmit_select & (master_select ? ~addr_phase
                                     : (addr_phase ? match : addressed))));
      end

      // Bus state monitor
      if (start_det) begin
         next_bb         = 1'b1;
         next_wl         = `TWS_WL_RESET;
         next_ad0        = 1'b0;
         next_bitcnt     = 4'h0;
         next_addr_phase = 1'b1;
         next_addressed  = 1'b0;
      end
      if (stop_det) begin
         next_bb         = 1'b0;
         next_ad0        = 1'b0;
         next_mst        = 1'b0;
         next_trx        = 1'b0;
         next_addressed  = 1'b0;
         next_addr_phase = 1'b0;
         next_stop_pend  = 1'b0;
         next_lost       = 1'b0;
      end

      // Clock generation and stretching
      next_cnt = cnt + 16'h0001;
      case (state)
         tws_pkg::TWS_IDLE: begin
            next_cnt = 16'h0000;
            if (start_pend & enable & ~pop & ~load_pend) begin
               next_state      = tws_pkg::TWS_START;
               next_sda_oe     = 1'b1;
               next_start_pend = 1'b0;
            end else if (~master_select & bb & ~pin & ~scl_i) begin
               next_scl_oe = 1'b1;  // Slave stretch
            end else if (scl_oe & pin) begin
               next_cnt = cnt + 16'h0001;
               if (low_done) begin
                  next_scl_oe = 1'b0;
               end
            end
         end
         tws_pkg::TWS_START: begin
            if (low_done) begin
               next_state  = tws_pkg::TWS_LOW;
               next_scl_oe = 1'b1;
               next_cnt    = 16'h0000;
            end
         end
         tws_pkg::TWS_LOW: begin
            if (~pin | load_pend & transmit_select) begin
               next_cnt = 16'h0000;  // SCL held while pending
            end else if (low_done) begin
               next_cnt    = 16'h0000;
               next_scl_oe = 1'b0;
               next_state  = stop_pend ? tws_pkg::TWS_STOP_HIGH
                                       : tws_pkg::TWS_HIGH;
            end
            if (stop_pend & pin & ~low_done) begin
               next_sda_oe = 1'b1;
               next_state  = tws_pkg::TWS_STOP_LOW;
            end
         end
         tws_pkg::TWS_HIGH: begin
            if (~scl_i) begin
               next_cnt = 16'h0000;  // Another master holds it low
            end else if (low_done | (scl_fall)) begin
               next_cnt    = 16'h0000;
               next_scl_oe = 1'b1;
               next_state  = tws_pkg::TWS_LOW;
            end
         end
         tws_pkg::TWS_STOP_LOW: begin
            next_sda_oe = 1'b1;
            if (low_done) begin
               next_cnt    = 16'h0000;
               next_scl_oe = 1'b0;
               next_state  = tws_pkg::TWS_STOP_HIGH;
            end
         end
         tws_pkg::TWS_STOP_HIGH: begin
            if (~scl_i) begin
               next_cnt = 16'h0000;  // Waits for a stretched SCL
            end else if (low_done) begin
               next_sda_oe = 1'b0;
               next_state  = tws_pkg::TWS_IDLE;
            end
         end
         default: begin
            next_state = tws_pkg::TWS_IDLE;
         end
      endcase

      // Leaving two-wire mode frees both lines
      if (~enable) begin
         next_state  = tws_pkg::TWS_IDLE;
         next_scl_oe = 1'b0;
         next_sda_oe = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state      <= tws_pkg::TWS_IDLE;
         cnt        <= 16'h0000;
         bitcnt     <= 4'h0;
         shreg      <= 8'h00;
         rxbuf      <= 8'h00;
         wl         <= `TWS_WL_RESET;
         mode       <= 2'h0;
         pin        <= 1'b1;
         {master_select, transmit_select, bb, al, address_hit_flag, ad0, last_bit_seen, irq} <= 8'h00;
         {addressed, lost, addr_phase, dir}     <= 4'h0;
         {load_pend, stop_pend, start_pend}     <= 3'h0;
         {scl_oe, sda_oe} <= 2'h0;
         {scl_q, sda_q}   <= 2'h3;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         bitcnt     <= next_bitcnt;
         shreg      <= next_shreg;
         rxbuf      <= next_rxbuf;
         wl         <= next_wl;
         mode       <= next_mode;
         pin        <= next_pin;
         {master_select, transmit_select, bb, al, address_hit_flag, ad0, last_bit_seen, irq} <=
            {next_mst, next_trx, next_bb, next_al, next_aas, next_ad0,
             next_lrb, next_irq};
         {addressed, lost, addr_phase, dir} <=
            {next_addressed, next_lost, next_addr_phase, next_dir};
         {load_pend, stop_pend, start_pend} <=
            {next_load_pend, next_stop_pend, next_start_pend};
         {scl_oe, sda_oe} <= {next_scl_oe, next_sda_oe};
         {scl_q, sda_q}   <= {scl_i, sda_i};
      end
   end

   // Outputs taken straight from flops; pins only ever pull low
   assign buf_rdata_o         = rxbuf;
   assign buf_ready_o         = tx_in.ready;
   assign serial_bus_irq_o    = irq;
   assign service_pending_n_o = pin;
   assign master_select_o     = master_select;
   assign transmit_select_o   = transmit_select;
   assign bus_busy_flag_o     = bb;
   assign arbitration_lost_o  = al;
   assign address_hit_flag_o  = address_hit_flag;
   assign zero_address_flag_o = ad0;
   assign last_bit_seen_o     = last_bit_seen;
   assign word_length_o       = wl;
   assign scl_o               = 1'b0;
   assign scl_oe_o            = scl_oe;
   assign sda_o               = 1'b0;
   assign sda_oe_o            = sda_oe;
endmodule

/* File: design/tws_fifo.sv */
`timescale 1ns/1ps
module tws_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic  clk_sys_i,
   input  wire logic  reset_i,
   // Fill and drain sides
   tws_stream_if.snk  in_s,
   tws_stream_if.src  out_s
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             not_full, next_not_full;
   logic             push, pop;

   // Handshakes; not_full kept as a flop so ready is clean
   assign push        = in_s.valid & not_full;
   assign pop         = out_s.ready & (count != '0);
   assign in_s.ready  = not_full;
   assign out_s.valid = (count != '0);
   assign out_s.data  = mem[rd_ptr];

   // Pointer and level update
   always_comb begin
      next_wr_ptr   = wr_ptr;
      next_rd_ptr   = rd_ptr;
      next_count    = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      next_count    = count + (AW+1)'(push) - (AW+1)'(pop);
      next_not_full = (next_count != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         count    <= '0;
         not_full <= 1'b1;
      end else begin
         wr_ptr   <= next_wr_ptr;
         rd_ptr   <= next_rd_ptr;
         count    <= next_count;
         not_full <= next_not_full;
      end
   end

   // Storage needs no reset
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr] <= in_s.data;
      end
   end
endmodule

/* File: shared/tws_pkg.sv */
package tws_pkg;
   typedef enum logic [2:0] {
      TWS_IDLE,
      TWS_START,
      TWS_LOW,
      TWS_HIGH,
      TWS_STOP_LOW,
      TWS_STOP_HIGH
   } tws_state_t;
   typedef logic [7:0] tws_byte_t;
endpackage

/* File: shared/tws_regs.svh */
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

`define TWS_CLK_NS        25
`define TWS_T_LOW_NS      5000
`define TWS_LOW_CYC       ((`TWS_T_LOW_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_T_START_US    98.0
`define TWS_MODE_TWO_WIRE 2'h2
`define TWS_MODE_BIT_HI   3
`define TWS_MODE_BIT_LO   2
`define TWS_WL_RESET      3'h0
`define TWS_WL_FULL       4'h8
`define TWS_FIFO_DEPTH    4
`define TWS_DATA_W        8

`endif

/* File: shared/tws_stream_if.sv */
`timescale 1ns/1ps
interface tws_stream_if #(parameter int WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: tb/tb_two_wire_bus_service_control.sv */
`timescale 1ns/1ps
module tb_two_wire_bus_service_control;
   localparam int LOW = 4;
   logic       clk_sys_i, reset_i, buf_wr_i, buf_rd_i, ctrl_b_wr_i, wl_wr, aas_o, ad0_o;
   logic       master_select, transmit_select, bbw, pin, ack_en, arb_pull, rdy;
   logic       irq, pend_n, mst_o, trx_o, bb_o, al_o, lrb_o, scl_oe, sda_oe, s_sda_oe;
   logic [1:0] mode;
   logic [2:0] wl, wl_o;
   logic [7:0] wdata, d, rx_byte, ex, rdata;
   wire        scl, sda;
   int         n_mismatch = 0, comparisons = 0, seed = 32'hB0D3, i;
   logic [2:0] expq[$];
   // Open-drain lines with pull-ups
   assign scl = ~scl_oe;
   assign sda = ~(sda_oe | s_sda_oe | arb_pull);
   tws_core #(.LOW_CYCLES(LOW), .FIFO_DEPTH(4)) uut (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .buf_wr_i(buf_wr_i), .buf_wdata_i(wdata),
      .buf_rd_i(buf_rd_i), .buf_rdata_o(rdata), .buf_ready_o(rdy), .ctrl_b_wr_i(ctrl_b_wr_i),
      .master_select_i(master_select), .transmit_select_i(transmit_select), .bus_busy_wr_i(bbw),
      .service_pending_wr_i(pin), .bus_mode_select_i(mode), .reply_bit_mode_i(1'b1),
      .clock_rate_select_i(3'h0), .word_length_wr_i(wl_wr), .word_length_i(wl),
      .own_address_i(7'h15), .free_format_select_i(1'b0), .serial_bus_irq_o(irq),
      .service_pending_n_o(pend_n), .master_select_o(mst_o), .transmit_select_o(trx_o),
      .bus_busy_flag_o(bb_o), .arbitration_lost_o(al_o), .address_hit_flag_o(aas_o),
      .zero_address_flag_o(ad0_o), .last_bit_seen_o(lrb_o), .word_length_o(wl_o),
      .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe));
   tws_bus_slave u_slave (.scl_i(scl), .sda_i(sda), .ack_en_i(ack_en),
      .sda_oe_o(s_sda_oe), .rx_byte_o(rx_byte));
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Control write: {master, transmit, busy, pending}
   task automatic ctrl(input logic [3:0] v);
      @(negedge clk_sys_i);
      {master_select, transmit_select, bbw, pin} = v;
      ctrl_b_wr_i = 1'b1;
      @(negedge clk_sys_i);
      ctrl_b_wr_i = 1'b0;
      @(negedge clk_sys_i);
   endtask
   task automatic bacc(input logic wr, input logic [7:0] v);
      @(negedge clk_sys_i);
      wdata = v;
      buf_wr_i = wr;
      buf_rd_i = !wr;
      @(negedge clk_sys_i);
      buf_wr_i = 1'b0;
      buf_rd_i = 1'b0;
      @(negedge clk_sys_i);
   endtask
   // Note the expected state, wait for the request, then see SCL stretched
   task automatic wait_req(input logic [2:0] e);
      expq.push_back(e);
      for (i = 0; i < 900 && pend_n !== 1'b0; i++)
         @(negedge clk_sys_i);
      repeat (6) @(negedge clk_sys_i);
      chk("scl_held", 8'h0, 8'(scl));
   endtask
   // Oldest note against {transmit, last bit, pending} after each request
   always @(negedge clk_sys_i) begin
      if (irq === 1'b1) begin
         repeat (2) @(negedge clk_sys_i);
         ex = (expq.size() > 0) ? 8'(expq.pop_front()) : 8'hFF;
         chk("req_state", ex, 8'({trx_o, lrb_o, pend_n}));
      end
   end
   task automatic complete_run;
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Whole run is well under a thousand cycles; allow far more
   initial begin
      #500000;
      n_mismatch++;
      $display("ERROR run expected finish seen timeout");
      complete_run();
   end
   initial begin
      {buf_wr_i, buf_rd_i, ctrl_b_wr_i, wl_wr, arb_pull, master_select, transmit_select, bbw, pin} = 9'h000;
      {mode, wl, wdata, d} = 21'h00000;
      ack_en = 1'b1;
      reset_i = 1'b1;
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      reset_i = 1'b0;
      // Slave receiver set-up, odd word length left to be reset by start
      wl = 3'h5;
      wl_wr = 1'b1;
      @(negedge clk_sys_i);
      wl_wr = 1'b0;
      chk("pins_idle", 8'h3, 8'({scl, sda}));
      mode = 2'h2;
      ctrl(4'h1);
      ctrl(4'h0);
      chk("pending", 8'h1, 8'(pend_n));
      // Write then read addressing, data words on the write pass only, stop
      for (int a = 0; a < 2; a++) begin
         ack_en = 1'b1;
         bacc(1'b1, 8'hA0 | a[7:0]);
         ctrl(4'hF);
         wait_req({!a[0], 2'b00});
         chk("busy", 8'h1, 8'(bb_o));
         chk("word_len", 8'h0, 8'(wl_o));
         if (a == 0) begin
            d = 8'($random(seed));
            bacc(1'b1, d);
            chk("scl_stretch", 8'h0, 8'(scl));
            wait_req(3'h4);
            chk("rx_byte", d, rx_byte);
            chk("rdata", d, rdata);
            ack_en = 1'b0;
            bacc(1'b1, 8'($random(seed)));
            wait_req(3'h6);
         end
         ctrl(4'hD);
         for (i = 0; i < 300 && bb_o !== 1'b0; i++)
            @(negedge clk_sys_i);
         chk("busy", 8'h0, 8'(bb_o));
      end
      // A rival pulls SDA low under our first address bit
      ack_en = 1'b1;
      bacc(1'b1, 8'hA0);
      ctrl(4'hF);
      for (i = 0; i < 300 && scl !== 1'b0; i++)
         @(negedge clk_sys_i);
      arb_pull = 1'b1;
      for (i = 0; i < 300 && al_o !== 1'b1; i++)
         @(negedge clk_sys_i);
      repeat (2) @(negedge clk_sys_i);
      chk("arb_lost", 8'h1, 8'(al_o));
      chk("roles", 8'h0, 8'({mst_o, trx_o}));
      chk("scl_free", 8'h1, 8'(scl));
      arb_pull = 1'b0;
      bacc(1'b0, 8'h00);
      chk("arb_lost", 8'h0, 8'(al_o));
      // Nothing drains while idle, so the fifth write is refused
      for (int k = 0; k < 5; k++)
         bacc(1'b1, 8'(k));
      chk("buf_ready", 8'h0, 8'(rdy));
      reset_i = 1'b1;
      repeat (8) @(negedge clk_sys_i);
      reset_i = 1'b0;
      @(negedge clk_sys_i);
      chk("reset_state", 8'hC, 8'({pend_n, rdy, aas_o, ad0_o}));
      chk("queue_left", 8'h0, 8'(expq.size()));
      complete_run();
   end
endmodule

/* File: tb/tws_bus_slave.sv */
`timescale 1ns/1ps
module tws_bus_slave (
   // Bus lines
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   // Scenario control
   input  wire logic       ack_en_i,
   // Pull-down and captured byte
   output logic            sda_oe_o,
   output logic      [7:0] rx_byte_o
);
   int         bits = 0;
   logic [7:0] shreg = 8'h00;
   initial sda_oe_o = 1'b0;
   initial rx_byte_o = 8'h00;
   // Start condition restarts the count
   always @(negedge sda_i) begin
      if (scl_i === 1'b1)
         bits = 0;
   end
   // Sample while SCL high, MSB first
   always @(posedge scl_i) begin
      if (bits < 8)
         shreg = {shreg[6:0], sda_i};
      bits = bits + 1;
   end
   // Ack set and released only at SCL falls, so no false start or stop
   always @(negedge scl_i) begin
      if (bits == 8) begin
         sda_oe_o = ack_en_i;
         rx_byte_o = shreg;
      end else if (bits >= 9) begin
         sda_oe_o = 1'b0;
         bits = 0;
      end
   end
endmodule

/* File: tb/tws_core_monitor.sv */
`timescale 1ns/1ps
module tws_core_monitor #(
   parameter int LOW_CYCLES = 200
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // Strobes
   input wire logic buf_wr_i,
   input wire logic buf_rd_i,
   input wire logic ctrl_b_wr_i,
   input wire logic service_pending_wr_i,
   // Status
   input wire logic serial_bus_irq_o,
   input wire logic service_pending_n_o,
   input wire logic master_select_o,
   input wire logic transmit_select_o,
   input wire logic bus_busy_flag_o,
   input wire logic arbitration_lost_o,
   // Bus pins
   input wire logic scl_i,
   input wire logic scl_oe_o,
   input wire logic sda_i,
   input wire logic sda_oe_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   int rel_cnt;
   // Cycles since the flag rose; saturates so clock phases never trip it
   always_ff @(posedge clk_sys_i) begin
      if (reset_i)
         rel_cnt <= LOW_CYCLES;
      else if ($rose(service_pending_n_o))
         rel_cnt <= 0;
      else if (rel_cnt < LOW_CYCLES)
         rel_cnt <= rel_cnt + 1;
   end
   property p_req_pend;
      serial_bus_irq_o && !arbitration_lost_o |-> ##[0:1] !service_pending_n_o;
   endproperty
   a_req_pend: assert property (p_req_pend) else $error("flag not cleared");
   property p_hold;
      !service_pending_n_o && $past(!service_pending_n_o) |-> scl_oe_o;
   endproperty
   a_hold: assert property (p_hold) else $error("scl not held");
   property p_release;
      $fell(scl_oe_o) && service_pending_n_o |-> rel_cnt >= LOW_CYCLES - 2;
   endproperty
   a_release: assert property (p_release) else $error("scl freed early");
   property p_buf_pend;
      buf_wr_i || buf_rd_i |=> service_pending_n_o || serial_bus_irq_o;
   endproperty
   a_buf_pend: assert property (p_buf_pend) else $error("access kept flag");
   property p_no_clear;
      ctrl_b_wr_i && !service_pending_wr_i |=> service_pending_n_o || !$past(service_pending_n_o);
   endproperty
   a_no_clear: assert property (p_no_clear) else $error("flag cleared by write");
   property p_al_cause;
      $rose(arbitration_lost_o) |-> $past(scl_i) && !$past(sda_i);
   endproperty
   a_al_cause: assert property (p_al_cause) else $error("loss without mismatch");
   property p_al_off;
      $rose(arbitration_lost_o) |->
         ##[0:1] !master_select_o && !transmit_select_o && !scl_oe_o && !sda_oe_o;
   endproperty
   a_al_off: assert property (p_al_off) else $error("lines kept after loss");
   property p_al_clear;
      buf_wr_i || buf_rd_i || ctrl_b_wr_i |=> !arbitration_lost_o;
   endproperty
   a_al_clear: assert property (p_al_clear) else $error("loss not cleared");
   property p_busy;
      $fell(sda_i) && scl_i && $past(scl_i) |-> ##[1:3] bus_busy_flag_o;
   endproperty
   a_busy: assert property (p_busy) else $error("start not seen");
   c_req: cover property (serial_bus_irq_o);
   c_lost: cover property ($rose(arbitration_lost_o));
   c_free: cover property ($fell(bus_busy_flag_o));
endmodule

bind tws_core tws_core_monitor #(.LOW_CYCLES(LOW_CYCLES)) u_mon (
   .clk_sys_i(clk_sys_i), .reset_i(reset_i), .buf_wr_i(buf_wr_i), .buf_rd_i(buf_rd_i),
   .ctrl_b_wr_i(ctrl_b_wr_i), .service_pending_wr_i(service_pending_wr_i),
   .serial_bus_irq_o(serial_bus_irq_o), .service_pending_n_o(service_pending_n_o),
   .master_select_o(master_select_o), .transmit_select_o(transmit_select_o),
   .bus_busy_flag_o(bus_busy_flag_o), .arbitration_lost_o(arbitration_lost_o),
   .scl_i(scl_i), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_oe_o(sda_oe_o));
